// ### logic/ccf_frames.v
/*
  Channel two and three setup frame decoder and holder.
  Assumes a deserialised frame arrives as a one-cycle strobe in clk domain.
  Bridge enable and timer-extension come from neighbouring frame logic.
*/
// Contract
// - Bits 31..28 carry command code 2,3,4.
// - Bit 27 zero writes, one only reads back.
// - Channel two bits 26..25 choose bridge off time.
// - Channel two bit 24 picks compensation factor.
// - Diagnostic timer ignored when bridge extends timers.
// - Bit 21 picks fixed or actual threshold readback.
// - Bits 20..15 hold overcurrent threshold code.
// - Bits 14..13 choose temperature compensation.
// - Bit 12 enables supply voltage compensation.
// - Bits 11..9 choose blanking time.
// - Bit 8 chooses re-engagement after overcurrent.
// - Bridge mode forces re-engagement after readout.
// - Bit 7 picks drain-source or shunt sensing.
// - Bit 6 picks open-load regulator current.
// - Bits 5..4 choose gate current.
// - Bit 2 low/high side, bit 3 N/P.
// - Bit 1 enables the channel output.
// - Bit 0 is odd parity over frame.
// - Channel three bit 26 enables bridge limiting when bit 7 picks shunt.
// - Channel three bit 25 selects active freewheel.
// - Channel three bit 24 picks gate boost mode.
// - Channel four bridge bit combines channels one-four.
// - Extended timer copies channel one timer.
`timescale 1ns/1ps
`include "ccf_map.vh"
module ccf_frames
(
   input wire clk, // 25 MHz clock
   input wire rst_n, // Asynchronous reset, active low
   input wire frame_valid, // One-cycle strobe of a received frame
   input wire [31:0] frame_in, // Received frame
   input wire bridge_one_enable, // Bridge one configured
   input wire bridge_one_timer_extension, // Bridge timer-extension selection
   input wire [1:0] ch1_tdiag, // Channel one diagnostic timer code
   input wire overcurrent_ch2, // Overcurrent seen on channel two
   input wire overcurrent_ch3, // Overcurrent seen on channel three
   input wire diag_read_done, // Diagnostics were read out
   input wire [5:0] actual_threshold_ch2, // Compensated threshold of channel two
   input wire [5:0] actual_threshold_ch3, // Compensated threshold of channel three
   output reg reply_valid, // One-cycle strobe of a reply frame
   output reg [31:0] reply_frame, // Readback frame
   output reg parity_error, // Last frame failed parity
   output reg ch4_frame_seen, // One-cycle strobe: channel four frame passed on
   output reg [1:0] bridge_one_limit_off_time, // Off time code
   output reg supply_comp_factor_select, // 0 passenger, 1 commercial factor
   output reg [1:0] tdiag_eff_ch2, // Effective diagnostic timer channel two
   output reg [1:0] tdiag_eff_ch3, // Effective diagnostic timer channel three
   output reg [5:0] overcurrent_threshold_code_ch2, // Threshold code channel two
   output reg [5:0] overcurrent_threshold_code_ch3, // Threshold code channel three
   output reg [1:0] thermal_threshold_compensation_ch2, // Thermal comp channel two
   output reg [1:0] thermal_threshold_compensation_ch3, // Thermal comp channel three
   output reg supply_threshold_compensation_ch2, // Supply comp channel two
   output reg supply_threshold_compensation_ch3, // Supply comp channel three
   output reg [2:0] overcurrent_blanking_time_ch2, // Blanking code channel two
   output reg [2:0] overcurrent_blanking_time_ch3, // Blanking code channel three
   output reg [1:0] overcurrent_sense_method, // Bit per channel, 1 shunt
   output reg [1:0] open_load_current_high, // Bit per channel, 1 mA capability
   output reg [1:0] gate_current_ch2, // Gate current code in use channel two
   output reg [1:0] gate_current_ch3, // Gate current code in use channel three
   output reg [1:0] high_side, // Bit per channel, 1 high side
   output reg [1:0] p_channel, // Bit per channel, 1 P-channel
   output reg [1:0] output_on, // Bit per channel, output running
   output reg bridge_one_current_limit_enable, // Limiting active
   output reg bridge_one_active_freewheel, // Active freewheel
   output reg gate_current_boost_mode // 0 selective, 1 global override
);
   // ==========================================================
   // Reset release
   // ==========================================================
   reg rst_m;
   reg rst_s;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_m <= 1'b0;
         rst_s <= 1'b0;
      end
      else
      begin
         rst_m <= 1'b1;
         rst_s <= rst_m;
      end
   end

   // ==========================================================
   // Frame decode
   // ==========================================================
   wire par_bit_in;
   wire par_ok;
   wire [31:0] reply_raw;
   wire reply_par;
   wire [3:0] cmd = frame_in[`CCF_CMD_HI:`CCF_CMD_LO];
   wire is_ch2 = (cmd == `CCF_CMD_CH2);
   wire is_ch3 = (cmd == `CCF_CMD_CH3);
   wire is_ch4 = (cmd == `CCF_CMD_CH4);
   wire do_write = frame_valid && par_ok && !frame_in[`CCF_RD_ONLY];

   ccf_parity u_par_in
   (
      .frame(frame_in),
      .par_bit(par_bit_in),
      .par_ok(par_ok)
   );

   // Stored configuration, bits 26..1 of each frame, index 0 = ch2, 1 = ch3.
   reg [`CCF_CFG_W-1:0] cfg [0:1];

   // ==========================================================
   // Per-channel storage and derived controls
   // ==========================================================
   // Latched overcurrent shutdown, cleared by re-engagement.
   reg [1:0] oc_latched;
   reg [1:0] readout_seen;
   reg [1:0] sw_prev;
   reg [1:0] gate_boosted [0:1];
   wire [1:0] oc_in = {overcurrent_ch3, overcurrent_ch2};

   // Gate current stepped up on overcurrent; codes 00 and 01 are left alone.
   function [1:0] boost_gcc;
      input [1:0] code;
      input glob;
      begin
         boost_gcc = code;
         if (code == `CCF_GCC_1MA)
            boost_gcc = glob ? `CCF_GCC_20MA : `CCF_GCC_5MA;
         else if (code == `CCF_GCC_5MA)
            boost_gcc = `CCF_GCC_20MA;
      end
   endfunction

   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1)
      begin : g_ch
         wire sel = (i == 0) ? is_ch2 : is_ch3;
         wire en = cfg[i][`CCF_EN-1];
         // Bridge mode always behaves as re-engage after readout.
         wire need_read = cfg[i][`CCF_PROT-1] | bridge_one_enable;
         always @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               cfg[i] <= `CCF_CFG_RST;
               oc_latched[i] <= 1'b0;
               readout_seen[i] <= 1'b0;
               sw_prev[i] <= 1'b0;
            end
            else if (!rst_s)
            begin
               cfg[i] <= `CCF_CFG_RST;
               oc_latched[i] <= 1'b0;
               readout_seen[i] <= 1'b0;
               sw_prev[i] <= 1'b0;
            end
            else
            begin
               if (do_write && sel)
                  cfg[i] <= frame_in[`CCF_RD_ONLY-1:1];
               sw_prev[i] <= en;
               // A new overcurrent wins over any re-engagement in the same cycle.
               if (oc_in[i])
               begin
                  oc_latched[i] <= 1'b1;
                  readout_seen[i] <= 1'b0;
               end
               else if (oc_latched[i])
               begin
                  if (diag_read_done)
                     readout_seen[i] <= 1'b1;
                  if ((en != sw_prev[i]) && (!need_read || readout_seen[i]))
                     oc_latched[i] <= 1'b0;
               end
            end
         end
         always @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               gate_boosted[i] <= `CCF_GCC_EXT;
            else
               gate_boosted[i] <= oc_in[i] ?
                  boost_gcc(cfg[i][`CCF_GCC_HI-1:`CCF_GCC_LO-1], cfg[1][`CCF_B24-1]) :
                  cfg[i][`CCF_GCC_HI-1:`CCF_GCC_LO-1];
         end
      end
   endgenerate

   // ==========================================================
   // Readback frame
   // ==========================================================
   wire [0:0] rsel = is_ch3 ? 1'b1 : 1'b0;
   wire [5:0] act_thr = is_ch3 ? actual_threshold_ch3 : actual_threshold_ch2;
   wire [`CCF_CFG_W-1:0] rcfg = cfg[rsel];
   // Threshold field reports compensated value when asked to.
   wire [5:0] thr_rb = rcfg[`CCF_OC_READ-1] ? act_thr : rcfg[`CCF_OC_HI-1:`CCF_OC_LO-1];
   assign reply_raw = {cmd, frame_in[`CCF_RD_ONLY], rcfg[`CCF_CFG_W-1:`CCF_OC_HI],
                       thr_rb, rcfg[`CCF_OC_LO-2:0], 1'b0};

   ccf_parity u_par_out
   (
      .frame(reply_raw),
      .par_bit(reply_par),
      .par_ok()
   );

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reply_valid <= 1'b0;
         reply_frame <= 32'h00000000;
         parity_error <= 1'b0;
         ch4_frame_seen <= 1'b0;
      end
      else if (!rst_s)
      begin
         reply_valid <= 1'b0;
         reply_frame <= 32'h00000000;
         parity_error <= 1'b0;
         ch4_frame_seen <= 1'b0;
      end
      else
      begin
         reply_valid <= frame_valid && par_ok && (is_ch2 || is_ch3);
         if (frame_valid && par_ok && (is_ch2 || is_ch3))
            reply_frame <= {reply_raw[31:1], reply_par};
         if (frame_valid)
            parity_error <= !par_ok;
         ch4_frame_seen <= frame_valid && par_ok && is_ch4;
      end
   end

   // ==========================================================
   // Registered control outputs
   // ==========================================================
   // With bridge one on and timer extension low, channel one's code goes to the other bridge legs.
   wire ext = bridge_one_enable && !bridge_one_timer_extension;

   // ==========================================================
   // Bridge one controls
   // ==========================================================
   // Bridge-wide fields live in their own process so that a change to the
   // bridge behaviour never touches the per-channel decode below.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bridge_one_limit_off_time <= 2'h0;
         supply_comp_factor_select <= 1'b0;
         bridge_one_current_limit_enable <= 1'b0;
         bridge_one_active_freewheel <= 1'b0;
         gate_current_boost_mode <= 1'b0;
      end
      else
      begin
         bridge_one_limit_off_time <= cfg[0][`CCF_B26-1:`CCF_B25-1];
         // Polarity follows the field's own printed encoding: one is commercial.
         supply_comp_factor_select <= cfg[0][`CCF_B24-1];
         // Limiting only makes sense with shunt measurement on channel three.
         bridge_one_current_limit_enable <= cfg[1][`CCF_B26-1] & cfg[1][`CCF_SHUNT-1];
         bridge_one_active_freewheel <= cfg[1][`CCF_B25-1];
         gate_current_boost_mode <= cfg[1][`CCF_B24-1];
      end
   end

   // ==========================================================
   // Channel two fields
   // ==========================================================
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tdiag_eff_ch2 <= 2'h0;
         overcurrent_threshold_code_ch2 <= 6'h00;
         thermal_threshold_compensation_ch2 <= `CCF_TCOMP_OFF;
         supply_threshold_compensation_ch2 <= 1'b0;
         overcurrent_blanking_time_ch2 <= 3'h0;
         gate_current_ch2 <= `CCF_GCC_EXT;
      end
      else
      begin
         tdiag_eff_ch2 <= ext ? ch1_tdiag : cfg[0][`CCF_TDIAG_HI-1:`CCF_TDIAG_LO-1];
         overcurrent_threshold_code_ch2 <= cfg[0][`CCF_OC_HI-1:`CCF_OC_LO-1];
         thermal_threshold_compensation_ch2 <= cfg[0][`CCF_TCOMP_HI-1:`CCF_TCOMP_LO-1];
         supply_threshold_compensation_ch2 <= cfg[0][`CCF_BCOMP-1];
         overcurrent_blanking_time_ch2 <= cfg[0][`CCF_BLANK_HI-1:`CCF_BLANK_LO-1];
         // The gate code passes two flops, so it trails the other fields by a cycle.
         gate_current_ch2 <= gate_boosted[0];
      end
   end

   // ==========================================================
   // Channel three fields
   // ==========================================================
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tdiag_eff_ch3 <= 2'h0;
         overcurrent_threshold_code_ch3 <= 6'h00;
         thermal_threshold_compensation_ch3 <= `CCF_TCOMP_OFF;
         supply_threshold_compensation_ch3 <= 1'b0;
         overcurrent_blanking_time_ch3 <= 3'h0;
         gate_current_ch3 <= `CCF_GCC_EXT;
      end
      else
      begin
         tdiag_eff_ch3 <= ext ? ch1_tdiag : cfg[1][`CCF_TDIAG_HI-1:`CCF_TDIAG_LO-1];
         overcurrent_threshold_code_ch3 <= cfg[1][`CCF_OC_HI-1:`CCF_OC_LO-1];
         thermal_threshold_compensation_ch3 <= cfg[1][`CCF_TCOMP_HI-1:`CCF_TCOMP_LO-1];
         supply_threshold_compensation_ch3 <= cfg[1][`CCF_BCOMP-1];
         overcurrent_blanking_time_ch3 <= cfg[1][`CCF_BLANK_HI-1:`CCF_BLANK_LO-1];
         gate_current_ch3 <= gate_boosted[1];
      end
   end

   // ==========================================================
   // Per-channel bit vectors
   // ==========================================================
   // Bit 0 of each vector is channel two and bit 1 is channel three.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         overcurrent_sense_method <= 2'h0;
         open_load_current_high <= 2'h0;
         high_side <= 2'h0;
         p_channel <= 2'h0;
         output_on <= 2'h0;
      end
      else
      begin
         overcurrent_sense_method <= {cfg[1][`CCF_SHUNT-1], cfg[0][`CCF_SHUNT-1]};
         open_load_current_high <= {cfg[1][`CCF_OLCUR-1], cfg[0][`CCF_OLCUR-1]};
         high_side <= {cfg[1][`CCF_LSHS-1], cfg[0][`CCF_LSHS-1]};
         // The P-channel choice only means something on a high-side channel.
         p_channel <= {cfg[1][`CCF_NP-1] & cfg[1][`CCF_LSHS-1],
                       cfg[0][`CCF_NP-1] & cfg[0][`CCF_LSHS-1]};
         output_on <= {cfg[1][`CCF_EN-1] & ~oc_latched[1],
                       cfg[0][`CCF_EN-1] & ~oc_latched[0]};
      end
   end
endmodule // ccf_frames

// ### logic/ccf_map.vh
/*
  Frame layout, command codes and field encodings for the channel two and
  three setup frame decoder. Assumes inclusion by bare name from logic/.
*/
`ifndef CCF_MAP_VH
`define CCF_MAP_VH
`define CCF_CMD_HI 31
`define CCF_CMD_LO 28
`define CCF_CMD_CH2 4'h2
`define CCF_CMD_CH3 4'h3
`define CCF_CMD_CH4 4'h4
`define CCF_RD_ONLY 27
`define CCF_B26 26
`define CCF_B25 25
`define CCF_B24 24
`define CCF_TDIAG_HI 23
`define CCF_TDIAG_LO 22
`define CCF_OC_READ 21
`define CCF_OC_HI 20
`define CCF_OC_LO 15
`define CCF_TCOMP_HI 14
`define CCF_TCOMP_LO 13
`define CCF_BCOMP 12
`define CCF_BLANK_HI 11
`define CCF_BLANK_LO 9
`define CCF_PROT 8
`define CCF_SHUNT 7
`define CCF_OLCUR 6
`define CCF_GCC_HI 5
`define CCF_GCC_LO 4
`define CCF_NP 3
`define CCF_LSHS 2
`define CCF_EN 1
`define CCF_PAR 0
`define CCF_CFG_W 26
`define CCF_CFG_RST 26'h0000000
`define CCF_GCC_EXT 2'h0
`define CCF_GCC_20MA 2'h1
`define CCF_GCC_5MA 2'h2
`define CCF_GCC_1MA 2'h3
`define CCF_TCOMP_OFF 2'h0
`endif

// ### logic/ccf_parity.v
/*
  Odd parity generator and checker over a 32-bit frame.
  Assumes the frame bit 0 carries the parity bit.
*/
`timescale 1ns/1ps
`include "ccf_map.vh"
module ccf_parity
(
   input wire [31:0] frame, // Frame under test
   output wire par_bit, // Parity bit the frame should carry
   output wire par_ok // Frame carries the right parity bit
);
   // One when the count of ones in bits 31..1 is even.
   assign par_bit = ~(^frame[31:1]);
   assign par_ok = (frame[`CCF_PAR] == par_bit);
endmodule // ccf_parity

// ### tb/ccf_frames_monitor.sv
/* Concurrent checks on the ports of ccf_frames.
   Assumes no frame arrives while the reset synchroniser still holds. */
`timescale 1ns/1ps
module ccf_frames_monitor
(
   input wire clk, // Clock
   input wire rst_n, // Reset, active low
   input wire frame_valid, // Frame strobe
   input wire [31:0] frame_in, // Frame
   input wire reply_valid, // Reply strobe
   input wire [31:0] reply_frame, // Reply
   input wire parity_error, // Parity fault
   input wire ch4_frame_seen, // Command four seen
   input wire [1:0] bridge_one_limit_off_time, // Off time
   input wire supply_comp_factor_select, // Factor
   input wire [5:0] overcurrent_threshold_code_ch2, // Threshold
   input wire [1:0] thermal_threshold_compensation_ch2, // Thermal
   input wire supply_threshold_compensation_ch2, // Supply
   input wire [2:0] overcurrent_blanking_time_ch2, // Blanking
   input wire bridge_one_current_limit_enable, // Limiting
   input wire bridge_one_active_freewheel, // Freewheel
   input wire gate_current_boost_mode // Boost mode
);
   // ==========
   // Frame checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // An odd count of ones over all 32 bits means the parity bit fits.
   wire good = ^frame_in;
   wire [3:0] cmd = frame_in[31:28];
   sequence s_wr2;
      frame_valid && good && cmd == 4'h2 && !frame_in[27];
   endsequence
   sequence s_wr3;
      frame_valid && good && cmd == 4'h3 && !frame_in[27];
   endsequence
   sequence s_rd2;
      frame_valid && good && cmd == 4'h2 && frame_in[27];
   endsequence
   property p_reply;
      frame_valid && good && (cmd == 4'h2 || cmd == 4'h3) |=>
         reply_valid && reply_frame[31:27] == $past(frame_in[31:27]) && ^reply_frame;
   endproperty
   a_reply: assert property (p_reply) else $error("reply missing or malformed");
   property p_bad;
      frame_valid && !good |=> parity_error && !reply_valid && !ch4_frame_seen;
   endproperty
   a_bad: assert property (p_bad) else $error("bad parity frame not refused");
   property p_ch4;
      frame_valid && good && cmd == 4'h4 |=> ch4_frame_seen && !reply_valid;
   endproperty
   a_ch4: assert property (p_ch4) else $error("command four not passed on");
   property p_noreply;
      reply_valid |-> $past(frame_valid);
   endproperty
   a_noreply: assert property (p_noreply) else $error("reply without a frame");
   property p_cfg2;
      s_wr2 |-> ##2 bridge_one_limit_off_time == $past(frame_in[26:25], 2)
         && supply_comp_factor_select == $past(frame_in[24], 2)
         && overcurrent_threshold_code_ch2 == $past(frame_in[20:15], 2);
   endproperty
   a_cfg2: assert property (p_cfg2) else $error("channel two fields wrong");
   property p_comp2;
      s_wr2 |-> ##2 overcurrent_blanking_time_ch2 == $past(frame_in[11:9], 2)
         && thermal_threshold_compensation_ch2 == $past(frame_in[14:13], 2)
         && supply_threshold_compensation_ch2 == $past(frame_in[12], 2);
   endproperty
   a_comp2: assert property (p_comp2) else $error("compensation fields wrong");
   property p_cfg3;
      s_wr3 |-> ##2 bridge_one_active_freewheel == $past(frame_in[25], 2)
         && gate_current_boost_mode == $past(frame_in[24], 2)
         && bridge_one_current_limit_enable == ($past(frame_in[26], 2) && $past(frame_in[7], 2));
   endproperty
   a_cfg3: assert property (p_cfg3) else $error("channel three fields wrong");
   property p_rdonly;
      s_rd2 |-> ##2 $stable(overcurrent_threshold_code_ch2) && $stable(bridge_one_limit_off_time);
   endproperty
   a_rdonly: assert property (p_rdonly) else $error("read-only frame changed setup");
endmodule // ccf_frames_monitor
bind ccf_frames ccf_frames_monitor mon (.clk, .rst_n, .frame_valid, .frame_in, .reply_valid, .reply_frame,
   .parity_error, .ch4_frame_seen, .bridge_one_limit_off_time, .supply_comp_factor_select,
   .overcurrent_threshold_code_ch2, .thermal_threshold_compensation_ch2, .supply_threshold_compensation_ch2,
   .overcurrent_blanking_time_ch2, .bridge_one_current_limit_enable, .bridge_one_active_freewheel,
   .gate_current_boost_mode);

// ### tb/ccf_frames_tb.sv
/* Self-checking testbench for the channel two and three setup frame decoder.
   Assumes the host model drives frames; all other inputs change at falling edges. */
`timescale 1ns/1ps
module ccf_frames_tb;
   // ==========
   // Bench
   localparam [25:0] B2 = {2'b10, 1'b1, 2'b01, 1'b0, 6'h2b, 2'b11, 1'b1, 3'b101, 3'b011, 2'b10, 3'b111};
   reg clk, rst_n, bridge_one_enable, bridge_one_timer_extension, overcurrent_ch2, overcurrent_ch3, rv;
   reg diag_read_done;
   reg [1:0] ch1_tdiag;
   reg [5:0] actual_threshold_ch2, actual_threshold_ch3;
   reg [31:0] rf;
   integer bad_count, checks_done, i;
   wire frame_valid, reply_valid, parity_error, ch4_frame_seen, supply_comp_factor_select;
   wire supply_threshold_compensation_ch2, bridge_one_current_limit_enable, bridge_one_active_freewheel;
   wire gate_current_boost_mode;
   wire [31:0] frame_in, reply_frame;
   wire [1:0] bridge_one_limit_off_time, tdiag_eff_ch2, thermal_threshold_compensation_ch2, gate_current_ch2;
   wire [1:0] overcurrent_sense_method, open_load_current_high, gate_current_ch3, high_side, p_channel, output_on;
   wire [5:0] overcurrent_threshold_code_ch2, overcurrent_threshold_code_ch3;
   wire [2:0] overcurrent_blanking_time_ch2;
   ccf_host host (.clk, .frame_valid, .frame_in, .reply_valid, .reply_frame);
   ccf_frames dut (.clk, .rst_n, .frame_valid, .frame_in, .bridge_one_enable, .bridge_one_timer_extension,
      .ch1_tdiag, .overcurrent_ch2, .overcurrent_ch3, .diag_read_done, .actual_threshold_ch2,
      .actual_threshold_ch3, .reply_valid, .reply_frame, .parity_error, .ch4_frame_seen,
      .bridge_one_limit_off_time, .supply_comp_factor_select, .tdiag_eff_ch2, .tdiag_eff_ch3(),
      .overcurrent_threshold_code_ch2, .overcurrent_threshold_code_ch3, .thermal_threshold_compensation_ch2,
      .thermal_threshold_compensation_ch3(), .supply_threshold_compensation_ch2,
      .supply_threshold_compensation_ch3(), .overcurrent_blanking_time_ch2, .overcurrent_blanking_time_ch3(),
      .overcurrent_sense_method, .open_load_current_high, .gate_current_ch2, .gate_current_ch3, .high_side,
      .p_channel, .output_on, .bridge_one_current_limit_enable, .bridge_one_active_freewheel,
      .gate_current_boost_mode);
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp)
         begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", checks_done, bad_count);
         if (bad_count == 0 && checks_done > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task do_reset;
      begin
         {bridge_one_enable, bridge_one_timer_extension, overcurrent_ch2, overcurrent_ch3, diag_read_done} = 5'h0;
         rst_n = 1'b0;
         repeat (5) @(negedge clk);
         rst_n = 1'b1;
         // The synchroniser holds the setup for two more edges.
         repeat (3) @(negedge clk);
      end
   endtask
   task send2(input b8, input en);
      host.send(4'h2, 1'b0, {18'h0, b8, 6'h0, en}, 1'b0, rv, rf);
   endtask
   // The switching event is a toggle of the stored enable bit.
   task reeng(input b8, input br, input exp);
      begin
         do_reset;
         bridge_one_enable = br;
         send2(b8, 1'b1);
         overcurrent_ch2 = 1'b1;
         @(negedge clk);
         overcurrent_ch2 = 1'b0;
         repeat (3) @(negedge clk);
         chk(output_on[0], 0);
         send2(b8, 1'b0);
         send2(b8, 1'b1);
         repeat (3) @(negedge clk);
         chk(output_on[0], exp);
         diag_read_done = 1'b1;
         @(negedge clk);
         diag_read_done = 1'b0;
         send2(b8, 1'b0);
         send2(b8, 1'b1);
         repeat (3) @(negedge clk);
         chk(output_on[0], 1);
      end
   endtask
   initial
   begin
      bad_count = 0;
      checks_done = 0;
      ch1_tdiag = 2'h3;
      actual_threshold_ch2 = 6'h15;
      actual_threshold_ch3 = 6'h2a;
      do_reset;
      host.send(4'h2, 1'b0, B2, 1'b0, rv, rf);
      chk(rv, 1);
      chk(rf, host.mk({4'h2, 1'b0, 26'h0}, 1'b0));
      repeat (2) @(negedge clk);
      chk({bridge_one_limit_off_time, supply_comp_factor_select, tdiag_eff_ch2}, 5'h15);
      chk({overcurrent_threshold_code_ch2, thermal_threshold_compensation_ch2}, 8'haf);
      chk({supply_threshold_compensation_ch2, overcurrent_blanking_time_ch2}, 4'hd);
      chk({overcurrent_sense_method[0], open_load_current_high[0], gate_current_ch2}, 4'he);
      chk({high_side[0], p_channel[0], output_on[0]}, 3'h7);
      host.send(4'h2, 1'b1, 26'h0, 1'b0, rv, rf);
      chk(rf, host.mk({4'h2, 1'b1, B2}, 1'b0));
      @(negedge clk);
      chk(overcurrent_threshold_code_ch2, 6'h2b);
      bridge_one_enable = 1'b1;
      repeat (3) @(negedge clk);
      chk(tdiag_eff_ch2, 3);
      bridge_one_timer_extension = 1'b1;
      repeat (3) @(negedge clk);
      chk(tdiag_eff_ch2, 1);
      $display("test channel two done");
      host.send(4'h2, 1'b0, ~B2, 1'b1, rv, rf);
      chk({rv, parity_error}, 2'h1);
      host.send(4'h4, 1'b0, 26'h0, 1'b0, rv, rf);
      chk({rv, parity_error, ch4_frame_seen}, 3'h1);
      host.send(4'h5, 1'b0, 26'h0, 1'b0, rv, rf);
      @(negedge clk);
      chk({rv, overcurrent_threshold_code_ch2}, 7'h2b);
      $display("test refusals done");
      host.send(4'h3, 1'b0, 26'h3144040, 1'b0, rv, rf);
      host.send(4'h3, 1'b1, 26'h0, 1'b0, rv, rf);
      chk({rv, rf[20:15]}, 7'h6a);
      chk(overcurrent_threshold_code_ch3, 6'h11);
      chk({bridge_one_current_limit_enable, bridge_one_active_freewheel, gate_current_boost_mode}, 3'h6);
      $display("test channel three done");
      for (i = 0; i < 8; i = i + 1)
      begin
         do_reset;
         host.send(4'h3, 1'b0, {2'b00, i[2], 18'h0, i[1:0], 3'b001}, 1'b0, rv, rf);
         repeat (2) @(negedge clk);
         chk(gate_current_ch3, i % 4);
         overcurrent_ch3 = 1'b1;
         repeat (3) @(negedge clk);
         chk(gate_current_ch3, (i % 4 < 2 || i > 3) ? (i % 4 != 0) : i % 4 - 1);
         chk(output_on[1], 0);
      end
      $display("test gate boost done");
      reeng(1'b0, 1'b0, 1'b1);
      reeng(1'b1, 1'b0, 1'b0);
      reeng(1'b0, 1'b1, 1'b0);
      $display("test re-engagement done");
      give_verdict;
   end
   initial
   begin
      #(40 * 5000);
      bad_count = bad_count + 1;
      give_verdict;
   end
endmodule // ccf_frames_tb

// ### tb/ccf_host.sv
/* Host model that sends setup frames to the frame decoder and returns its reply.
   Assumes a free-running clk; it drives only just after the falling edge. */
`timescale 1ns/1ps
module ccf_host
(
   input wire clk, // Clock
   output reg frame_valid, // Frame strobe
   output reg [31:0] frame_in, // Frame
   input wire reply_valid, // Reply strobe
   input wire [31:0] reply_frame // Reply
);
   // ==========
   // Frame sender
   initial
   begin
      frame_valid = 1'b0;
      frame_in = 32'h0;
   end
   function [31:0] mk;
      input [30:0] top;
      input bad;
      mk = {top, ~^top ^ bad};
   endfunction
   task send;
      input [3:0] cmd;
      input rd;
      input [25:0] body;
      input bad;
      output rv;
      output [31:0] rf;
      begin
         @(negedge clk);
         frame_valid = 1'b1;
         frame_in = mk({cmd, rd, body}, bad);
         @(negedge clk);
         frame_valid = 1'b0;
         // Idle bus shows the inverse so a stale frame cannot pass for a new one.
         frame_in = ~frame_in;
         rv = reply_valid;
         rf = reply_frame;
      end
   endtask
endmodule // ccf_host
